// >>> core/dsrf_params.svh
/*
 * offsets, field positions, reset values and steps of the dsp register file
 * assumes: included by bare name, definitions only
 */
`ifndef DSRF_PARAMS_SVH
`define DSRF_PARAMS_SVH

`define DSRF_OFF_GPR0       8'h00
`define DSRF_OFF_STATUS     8'h40
`define DSRF_OFF_LOOP_START 8'h44
`define DSRF_OFF_LOOP_END   8'h48
`define DSRF_OFF_WRAP       8'h4C
`define DSRF_OFF_DSP_FLAGS  8'h50
`define DSRF_OFF_ACC0_LO    8'h60
`define DSRF_OFF_ACC0_HI    8'h64
`define DSRF_OFF_ACC1_LO    8'h68
`define DSRF_OFF_ACC1_HI    8'h6C
`define DSRF_OFF_X0         8'h70
`define DSRF_OFF_X1         8'h74
`define DSRF_OFF_Y0         8'h78
`define DSRF_OFF_Y1         8'h7C
`define DSRF_OFF_M0         8'h80
`define DSRF_OFF_M1         8'h84

`define DSRF_RC_MSB         27
`define DSRF_RC_LSB         16
`define DSRF_DMY_BIT        11
`define DSRF_DMX_BIT        10

`define DSRF_STATUS_RST     32'h000000F0
`define DSRF_SP_RST         32'h00000000
`define DSRF_SP_FRAME       32'h00000008
`define DSRF_PTR_STEP       32'h00000002

`endif

// >>> core/dsrf_pkg.sv
/*
 * types shared by the dsp register file
 * assumes: nothing
 */
package dsrf_pkg;
	typedef enum logic [1:0] {
		DSRF_AM_NONE,
		DSRF_AM_INC,
		DSRF_AM_DEC,
		DSRF_AM_INDEX
	} dsrf_amode_t;

	typedef enum logic [1:0] {
		DSRF_CTL_STATUS,
		DSRF_CTL_LOOP_START,
		DSRF_CTL_LOOP_END,
		DSRF_CTL_WRAP
	} dsrf_ctl_t;
endpackage : dsrf_pkg

// >>> core/dsrf_agu.sv
/*
 * one dsp address unit: next pointer value
 * assumes: combinational, pointer written back by the register file
 */
`timescale 1ns/1ps
`include "dsrf_params.svh"
module dsrf_agu (
	input  wire logic [31:0]          ptr,
	input  wire logic [31:0]          index,
	input  dsrf_pkg::dsrf_amode_t     mode,
	input  wire logic                 wrap_en,
	input  wire logic [15:0]          wrap_start,
	input  wire logic [15:0]          wrap_end,
	output logic      [31:0]          ptr_nxt
);
	always_comb begin
		case (mode)
			dsrf_pkg::DSRF_AM_INC:   ptr_nxt = ptr + `DSRF_PTR_STEP;
			dsrf_pkg::DSRF_AM_DEC:   ptr_nxt = ptr - `DSRF_PTR_STEP;
			dsrf_pkg::DSRF_AM_INDEX: ptr_nxt = ptr + index;
			default:                 ptr_nxt = ptr;
		endcase
		// wrap back to start on reaching the end address
		if (wrap_en && mode != dsrf_pkg::DSRF_AM_NONE && ptr[15:0] == wrap_end) begin
			ptr_nxt = {ptr[31:16], wrap_start};
		end
	end
endmodule : dsrf_agu

// >>> core/dsrf_mul.sv
/*
 * single-cycle signed fixed-point multiplier
 * assumes: operands are the upper halves of dsp data registers
 */
`timescale 1ns/1ps
module dsrf_mul (
	input  wire logic [15:0] op_a,
	input  wire logic [15:0] op_b,
	output logic      [31:0] product
);
	logic signed [31:0] full;

	always_comb begin
		full    = $signed(op_a) * $signed(op_b);
		product = {full[30:0], 1'b0};
	end
endmodule : dsrf_mul

// >>> core/dsrf_top.sv
/*
 * dsp cpu register file: general, control, system and dsp data registers,
 * two address units, loop control, multiplier, apb debug access
 * assumes: pipeline strobes come from logic on pclk; no synchronisers
 */
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "dsrf_params.svh"
module dsrf_top #(
	parameter int ACC_W = 40
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   ce,
	// apb
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// general register ports
	input  wire logic [3:0]             rd_a_idx,
	input  wire logic [3:0]             rd_b_idx,
	output logic      [31:0]            rd_a_data,
	output logic      [31:0]            rd_b_data,
	input  wire logic                   gpr_wr_en,
	input  wire logic [3:0]             gpr_wr_idx,
	input  wire logic [31:0]            gpr_wr_data,
	output logic      [31:0]            index_gpr_zero,
	output logic      [31:0]            stack_pointer,
	input  wire logic                   exc_push,
	input  wire logic                   exc_pop,
	// control and system registers
	input  wire logic                   ctl_wr_en,
	input  dsrf_pkg::dsrf_ctl_t         ctl_wr_sel,
	input  wire logic [31:0]            ctl_wr_data,
	input  wire logic                   flags_wr_en,
	input  wire logic [31:0]            flags_wr_data,
	output logic      [31:0]            status_word,
	output logic      [31:0]            loop_start_pointer,
	output logic      [31:0]            loop_end_pointer,
	output logic      [31:0]            wraparound_bounds,
	output logic      [31:0]            dsp_flags,
	// loop control
	input  wire logic                   fetch_valid,
	input  wire logic [31:0]            fetch_pc,
	output logic                        loop_redirect,
	output logic      [31:0]            loop_target,
	// address units
	input  dsrf_pkg::dsrf_amode_t       x_mode,
	input  wire logic                   x_sel,
	input  dsrf_pkg::dsrf_amode_t       y_mode,
	input  wire logic                   y_sel,
	output logic      [31:0]            x_addr,
	output logic      [31:0]            y_addr,
	// dsp data registers
	input  wire logic                   dsp_valid,
	input  wire logic                   dsp_is_32,
	input  wire logic                   dsp_has_arith,
	output logic                        dsp_len_err,
	input  wire logic                   alu_wr_en,
	input  wire logic [2:0]             alu_wr_idx,
	input  wire logic [ACC_W-1:0]       alu_wr_data,
	input  wire logic                   mul_en,
	input  wire logic                   mul_dst,
	input  wire logic                   ld_x_en,
	input  wire logic                   ld_x_dst,
	input  wire logic [31:0]            ld_x_data,
	input  wire logic                   ld_y_en,
	input  wire logic                   ld_y_dst,
	input  wire logic [31:0]            ld_y_data,
	input  wire logic [2:0]             dsp_rd_idx,
	output logic      [ACC_W-1:0]       dsp_rd_data
);
	generate
		if (ACC_W <= 32 || ACC_W > 64) begin : g_chk
			$error("ACC_W must lie in 33..64");
		end
	endgenerate

	localparam int GW = ACC_W - 32;

	logic [31:0]      gpr_r [16];
	logic [31:0]      gpr_nxt [16];
	logic [31:0]      status_r;
	logic [31:0]      loop_start_r;
	logic [31:0]      loop_end_r;
	logic [31:0]      wrap_r;
	logic [31:0]      flags_r;
	logic [ACC_W-1:0] acc_r [2];
	logic [31:0]      data_r [6];
	logic [31:0]      x_ptr_nxt;
	logic [31:0]      y_ptr_nxt;
	logic [31:0]      product;
	logic [11:0]      rc;
	logic             apb_wr;
	logic [7:0]       a8;
	logic             hit;
	logic [31:0]      rdata;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// same-cycle bypass of pipeline port writes; bus, address unit and stack pointer updates are not forwarded
	function automatic logic [31:0] fwd(input logic [3:0] idx, input logic we,
		input logic [3:0] widx, input logic [31:0] wd, input logic [31:0] cur);
		fwd = (we && idx == widx) ? wd : cur;
	endfunction : fwd

	function automatic logic [ACC_W-1:0] sext32(input logic [31:0] v);
		sext32 = {{GW{v[31]}}, v};
	endfunction : sext32

	////////////////////////////////////////////////////////////////////////////
	// apb decode; zero wait states, frozen with the clock enable

	assign a8      = paddr[7:0];
	assign pready  = ce;
	assign apb_wr  = psel && penable && pwrite && ce && hit;
	assign pslverr = psel && penable && !hit;

	always_comb begin
		hit   = (paddr[11:8] == 4'h0);
		rdata = 32'h00000000;
		if (a8 < `DSRF_OFF_STATUS) begin
			rdata = gpr_r[a8[5:2]];
		end else begin
			case (a8)
				`DSRF_OFF_STATUS:     rdata = status_r;
				`DSRF_OFF_LOOP_START: rdata = loop_start_r;
				`DSRF_OFF_LOOP_END:   rdata = loop_end_r;
				`DSRF_OFF_WRAP:       rdata = wrap_r;
				`DSRF_OFF_DSP_FLAGS:  rdata = flags_r;
				`DSRF_OFF_ACC0_LO:    rdata = acc_r[0][31:0];
				`DSRF_OFF_ACC0_HI:    rdata = 32'(acc_r[0][ACC_W-1:32]);
				`DSRF_OFF_ACC1_LO:    rdata = acc_r[1][31:0];
				`DSRF_OFF_ACC1_HI:    rdata = 32'(acc_r[1][ACC_W-1:32]);
				`DSRF_OFF_X0:         rdata = data_r[0];
				`DSRF_OFF_X1:         rdata = data_r[1];
				`DSRF_OFF_Y0:         rdata = data_r[2];
				`DSRF_OFF_Y1:         rdata = data_r[3];
				`DSRF_OFF_M0:         rdata = data_r[4];
				`DSRF_OFF_M1:         rdata = data_r[5];
				default:              hit = 1'b0;
			endcase
		end
		if (paddr[1:0] != 2'b00) begin
			hit = 1'b0;
		end
		if (!hit) begin
			rdata = 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (ce && psel && !penable && !pwrite) begin
			prdata <= rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// address units: x on R4/R5 indexed by R8, y on R6/R7 indexed by R9

	dsrf_agu u_agu_x (
		.ptr        (gpr_r[x_sel ? 5 : 4]),
		.index      (gpr_r[8]),
		.mode       (x_mode),
		.wrap_en    (status_r[`DSRF_DMX_BIT]),
		.wrap_start (wrap_r[15:0]),
		.wrap_end   (wrap_r[31:16]),
		.ptr_nxt    (x_ptr_nxt)
	);

	// x wins when both wrap enables are set
	dsrf_agu u_agu_y (
		.ptr        (gpr_r[y_sel ? 7 : 6]),
		.index      (gpr_r[9]),
		.mode       (y_mode),
		.wrap_en    (status_r[`DSRF_DMY_BIT] && !status_r[`DSRF_DMX_BIT]),
		.wrap_start (wrap_r[15:0]),
		.wrap_end   (wrap_r[31:16]),
		.ptr_nxt    (y_ptr_nxt)
	);

	assign x_addr = gpr_r[x_sel ? 5 : 4];
	assign y_addr = gpr_r[y_sel ? 7 : 6];

	////////////////////////////////////////////////////////////////////////////
	// general registers; later writers take priority

	always_comb begin
		for (int i = 0; i < 16; i++) begin
			gpr_nxt[i] = gpr_r[i];
		end
		if (apb_wr && a8 < `DSRF_OFF_STATUS) begin
			gpr_nxt[a8[5:2]] = pwdata;
		end
		if (gpr_wr_en) begin
			gpr_nxt[gpr_wr_idx] = gpr_wr_data;
		end
		// idle units must not mask bus or pipeline writes to their pointers
		if (x_mode != dsrf_pkg::DSRF_AM_NONE) begin
			gpr_nxt[x_sel ? 5 : 4] = x_ptr_nxt;
		end
		if (y_mode != dsrf_pkg::DSRF_AM_NONE) begin
			gpr_nxt[y_sel ? 7 : 6] = y_ptr_nxt;
		end
		if (exc_push) begin
			gpr_nxt[15] = gpr_r[15] - `DSRF_SP_FRAME;
		end else if (exc_pop) begin
			gpr_nxt[15] = gpr_r[15] + `DSRF_SP_FRAME;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 15; i++) begin
				gpr_r[i] <= 32'h00000000;
			end
			gpr_r[15] <= `DSRF_SP_RST;
		end else if (ce) begin
			for (int i = 0; i < 16; i++) begin
				gpr_r[i] <= gpr_nxt[i];
			end
		end
	end

	assign rd_a_data      = fwd(rd_a_idx, gpr_wr_en, gpr_wr_idx, gpr_wr_data, gpr_r[rd_a_idx]);
	assign rd_b_data      = fwd(rd_b_idx, gpr_wr_en, gpr_wr_idx, gpr_wr_data, gpr_r[rd_b_idx]);
	assign index_gpr_zero = gpr_r[0];
	assign stack_pointer  = gpr_r[15];

	////////////////////////////////////////////////////////////////////////////
	// control registers and zero-overhead loop

	assign rc            = status_r[`DSRF_RC_MSB:`DSRF_RC_LSB];
	assign loop_redirect = fetch_valid && fetch_pc == loop_end_r && rc > 12'h001;
	assign loop_target   = loop_start_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= `DSRF_STATUS_RST;
		end else if (ce) begin
			if (ctl_wr_en && ctl_wr_sel == dsrf_pkg::DSRF_CTL_STATUS) begin
				status_r <= ctl_wr_data;
			end else if (apb_wr && a8 == `DSRF_OFF_STATUS) begin
				status_r <= pwdata;
			end else if (loop_redirect) begin
				status_r[`DSRF_RC_MSB:`DSRF_RC_LSB] <= rc - 12'h001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_start_r <= 32'h00000000;
			loop_end_r   <= 32'h00000000;
			wrap_r       <= 32'h00000000;
		end else if (ce) begin
			if (ctl_wr_en && ctl_wr_sel == dsrf_pkg::DSRF_CTL_LOOP_START) begin
				loop_start_r <= ctl_wr_data;
			end else if (apb_wr && a8 == `DSRF_OFF_LOOP_START) begin
				loop_start_r <= pwdata;
			end
			if (ctl_wr_en && ctl_wr_sel == dsrf_pkg::DSRF_CTL_LOOP_END) begin
				loop_end_r <= ctl_wr_data;
			end else if (apb_wr && a8 == `DSRF_OFF_LOOP_END) begin
				loop_end_r <= pwdata;
			end
			if (ctl_wr_en && ctl_wr_sel == dsrf_pkg::DSRF_CTL_WRAP) begin
				wrap_r <= ctl_wr_data;
			end else if (apb_wr && a8 == `DSRF_OFF_WRAP) begin
				wrap_r <= pwdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= 32'h00000000;
		end else if (ce) begin
			if (flags_wr_en) begin
				flags_r <= flags_wr_data;
			end else if (apb_wr && a8 == `DSRF_OFF_DSP_FLAGS) begin
				flags_r <= pwdata;
			end
		end
	end

	assign status_word        = status_r;
	assign loop_start_pointer = loop_start_r;
	assign loop_end_pointer   = loop_end_r;
	assign wraparound_bounds  = wrap_r;
	assign dsp_flags          = flags_r;

	////////////////////////////////////////////////////////////////////////////
	// dsp data registers: writeback stage takes alu, multiply and two moves

	dsrf_mul u_mul (
		.op_a    (data_r[0][31:16]),
		.op_b    (data_r[2][31:16]),
		.product (product)
	);

	assign dsp_len_err = dsp_valid && !dsp_is_32 && dsp_has_arith;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r[0] <= '0;
			acc_r[1] <= '0;
			for (int i = 0; i < 6; i++) begin
				data_r[i] <= 32'h00000000;
			end
		end else if (ce) begin
			if (apb_wr) begin
				case (a8)
					`DSRF_OFF_ACC0_LO: acc_r[0][31:0] <= pwdata;
					`DSRF_OFF_ACC0_HI: acc_r[0][ACC_W-1:32] <= pwdata[GW-1:0];
					`DSRF_OFF_ACC1_LO: acc_r[1][31:0] <= pwdata;
					`DSRF_OFF_ACC1_HI: acc_r[1][ACC_W-1:32] <= pwdata[GW-1:0];
					`DSRF_OFF_X0:      data_r[0] <= pwdata;
					`DSRF_OFF_X1:      data_r[1] <= pwdata;
					`DSRF_OFF_Y0:      data_r[2] <= pwdata;
					`DSRF_OFF_Y1:      data_r[3] <= pwdata;
					`DSRF_OFF_M0:      data_r[4] <= pwdata;
					`DSRF_OFF_M1:      data_r[5] <= pwdata;
					default: ;
				endcase
			end
			if (ld_x_en) begin
				data_r[ld_x_dst ? 1 : 0] <= ld_x_data;
			end
			if (ld_y_en) begin
				data_r[ld_y_dst ? 3 : 2] <= ld_y_data;
			end
			if (mul_en) begin
				data_r[mul_dst ? 5 : 4] <= product;
			end
			if (alu_wr_en) begin
				if (alu_wr_idx < 3'd2) begin
					acc_r[alu_wr_idx[0]] <= alu_wr_data;
				end else begin
					data_r[alu_wr_idx - 3'd2] <= alu_wr_data[31:0];
				end
			end
		end
	end

	always_comb begin
		if (dsp_rd_idx < 3'd2) begin
			dsp_rd_data = acc_r[dsp_rd_idx[0]];
		end else begin
			dsp_rd_data = sext32(data_r[dsp_rd_idx - 3'd2]);
		end
	end
endmodule : dsrf_top

// >>> verif/dsrf_top_asserts.sv
/*
 * concurrent checks on the ports of the dsp register file
 * assumes: bound to dsrf_top from the bench, single pclk domain
 */
`timescale 1ns/1ps
`include "dsrf_params.svh"
module dsrf_top_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        gpr_wr_en,
	input wire logic [3:0]  gpr_wr_idx,
	input wire logic [31:0] gpr_wr_data,
	input wire logic [3:0]  rd_a_idx,
	input wire logic [31:0] rd_a_data,
	input wire logic [31:0] index_gpr_zero,
	input wire logic [31:0] stack_pointer,
	input wire logic        exc_push,
	input wire logic        exc_pop,
	input wire logic        ctl_wr_en,
	input wire logic [31:0] status_word,
	input wire logic [31:0] loop_start_pointer,
	input wire logic [31:0] loop_end_pointer,
	input wire logic        fetch_valid,
	input wire logic [31:0] fetch_pc,
	input wire logic        loop_redirect,
	input wire logic [31:0] loop_target,
	input wire logic        dsp_valid,
	input wire logic        dsp_is_32,
	input wire logic        dsp_has_arith,
	input wire logic        dsp_len_err
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
////////////////////////////////////////
	sequence s_loop_taken;
		loop_redirect && ce && !ctl_wr_en && !(psel && penable && pwrite);
	endsequence
	sequence s_count_down;
		status_word[27:16] == $past(status_word[27:16]) - 12'h001;
	endsequence
	a_loop_count_dec: assert property (s_loop_taken |=> s_count_down)
		else $error("loop count did not step down by one");
	a_redirect_cause: assert property (loop_redirect |-> fetch_pc == loop_end_pointer
		&& status_word[27:16] > 12'h001 && loop_target == loop_start_pointer)
		else $error("loop redirect without its cause");
	a_redirect_taken: assert property (fetch_valid && fetch_pc == loop_end_pointer
		&& status_word[27:16] > 12'h001 |-> loop_redirect)
		else $error("loop end reached but no redirect");
	a_stack_push: assert property (exc_push && ce |=> stack_pointer == $past(stack_pointer) - 32'h00000008)
		else $error("stack pointer push step wrong");
	a_stack_pop: assert property (exc_pop && !exc_push && ce |=>
		stack_pointer == $past(stack_pointer) + 32'h00000008)
		else $error("stack pointer pop step wrong");
	a_read_bypass: assert property (gpr_wr_en && ce && rd_a_idx == gpr_wr_idx |-> rd_a_data == gpr_wr_data)
		else $error("same cycle read missed the write");
	a_index_write: assert property (gpr_wr_en && ce && gpr_wr_idx == 4'h0 |=>
		index_gpr_zero == $past(gpr_wr_data))
		else $error("index register not written");
	a_status_reset: assert property ($rose(presetn) |->
		status_word == `DSRF_STATUS_RST && stack_pointer == `DSRF_SP_RST)
		else $error("reset values wrong");
	a_len_err_decode: assert property (dsp_len_err == (dsp_valid && !dsp_is_32 && dsp_has_arith))
		else $error("length error decode wrong");
endmodule : dsrf_top_asserts

// >>> verif/dsrf_fetch_model.sv
/*
 * fetch side model: steps the program counter, follows loop redirects
 * assumes: run held high for a whole loop pass, start_pc stable
 */
`timescale 1ns/1ps
module dsrf_fetch_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        run,
	input  wire logic [31:0] start_pc,
	input  wire logic        loop_redirect,
	input  wire logic [31:0] loop_target,
	output logic             fetch_valid,
	output logic      [31:0] fetch_pc
);
////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_valid <= 1'b0;
			fetch_pc    <= 32'h00000000;
		end else if (!run) begin
			fetch_valid <= 1'b0;
			fetch_pc    <= start_pc;
		end else begin
			fetch_valid <= 1'b1;
			if (fetch_valid) begin
				fetch_pc <= loop_redirect ? loop_target : fetch_pc + 32'h00000002;
			end
		end
	end
endmodule : dsrf_fetch_model

// >>> verif/tb_top.sv
/*
 * self-checking bench for the dsp register file
 * assumes: dsrf_top, fetch model and checker compiled first
 */
`timescale 1ns/1ps
`include "dsrf_params.svh"
module tb_top;
	logic                  pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata, q, rd_a_data, rd_b_data, gpr_wr_data, index_gpr_zero, stack_pointer;
	logic [3:0]            rd_a_idx, rd_b_idx, gpr_wr_idx;
	logic                  gpr_wr_en, exc_push, exc_pop, ctl_wr_en, flags_wr_en, fetch_valid, loop_redirect, run;
	dsrf_pkg::dsrf_ctl_t   ctl_wr_sel;
	logic [31:0]           ctl_wr_data, flags_wr_data, status_word, loop_start_pointer, loop_end_pointer;
	logic [31:0]           wraparound_bounds, dsp_flags, fetch_pc, loop_target, x_addr, y_addr, ld_x_data, ld_y_data;
	dsrf_pkg::dsrf_amode_t x_mode, y_mode;
	logic                  x_sel, y_sel, dsp_valid, dsp_is_32, dsp_has_arith, dsp_len_err, alu_wr_en, mul_en;
	logic                  mul_dst, ld_x_en, ld_x_dst, ld_y_en, ld_y_dst;
	logic [2:0]            alu_wr_idx, dsp_rd_idx;
	logic [39:0]           alu_wr_data, dsp_rd_data;
	int                    mismatches, cmp_count, n;

	dsrf_top #(.ACC_W(40)) dsrf_top_inst (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .rd_a_idx, .rd_b_idx, .rd_a_data, .rd_b_data, .gpr_wr_en, .gpr_wr_idx,
		.gpr_wr_data, .index_gpr_zero, .stack_pointer, .exc_push, .exc_pop, .ctl_wr_en, .ctl_wr_sel,
		.ctl_wr_data, .flags_wr_en, .flags_wr_data, .status_word, .loop_start_pointer, .loop_end_pointer,
		.wraparound_bounds, .dsp_flags, .fetch_valid, .fetch_pc, .loop_redirect, .loop_target, .x_mode,
		.x_sel, .y_mode, .y_sel, .x_addr, .y_addr, .dsp_valid, .dsp_is_32, .dsp_has_arith, .dsp_len_err,
		.alu_wr_en, .alu_wr_idx, .alu_wr_data, .mul_en, .mul_dst, .ld_x_en, .ld_x_dst, .ld_x_data,
		.ld_y_en, .ld_y_dst, .ld_y_data, .dsp_rd_idx, .dsp_rd_data);
	dsrf_fetch_model dsrf_fetch_model_inst (.pclk, .presetn, .run, .start_pc(32'h00000100), .loop_redirect,
		.loop_target, .fetch_valid, .fetch_pc);

	always #5 pclk = ~pclk;
////////////////////////////////////////
	function automatic logic [31:0] d(input int i);
		return 32'h5A000000 + 32'(i) * 32'h00010203;
	endfunction : d
	task automatic results();
		$display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int k;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			mismatches++;
			$display("wrong value at %0t: bus answer missing", $time);
			results();
		end
		@(posedge pclk);
	endtask : apb
	task automatic ctl(input dsrf_pkg::dsrf_ctl_t s, input logic [31:0] wd);
		ctl_wr_en   <= 1'b1;
		ctl_wr_sel  <= s;
		ctl_wr_data <= wd;
		@(posedge pclk);
		ctl_wr_en <= 1'b0;
		@(posedge pclk);
	endtask : ctl
	task automatic step_chk(input logic [39:0] e);
		@(posedge pclk);
		#1 chk(stack_pointer, e);
	endtask : step_chk
	task automatic dchk(input logic [2:0] i, input logic [39:0] e);
		dsp_rd_idx <= i;
		@(posedge pclk);
		#1 chk(dsp_rd_data, e);
	endtask : dchk
////////////////////////////////////////
	initial begin
		{pclk, presetn, psel, penable, pwrite, gpr_wr_en, exc_push, exc_pop, ctl_wr_en, flags_wr_en, run} = '0;
		{x_sel, y_sel, dsp_valid, dsp_is_32, dsp_has_arith, alu_wr_en, mul_en, mul_dst, ld_x_en, ld_x_dst} = '0;
		{ld_y_en, ld_y_dst, paddr, pwdata, rd_a_idx, rd_b_idx, gpr_wr_idx, gpr_wr_data, ctl_wr_data} = '0;
		{flags_wr_data, ld_x_data, ld_y_data, alu_wr_idx, dsp_rd_idx, alu_wr_data, mismatches, cmp_count} = '0;
		ce = 1'b1;
		x_mode = dsrf_pkg::DSRF_AM_NONE;
		y_mode = dsrf_pkg::DSRF_AM_NONE;
		ctl_wr_sel = dsrf_pkg::DSRF_CTL_STATUS;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, 12'h040, '0);
		chk(q, `DSRF_STATUS_RST);
		apb(0, 12'h03C, '0);
		chk(q, `DSRF_SP_RST);
		for (int i = 0; i < 16; i++) apb(1, 12'(4 * i), d(i));
		for (int i = 0; i < 16; i++) begin
			apb(0, 12'(4 * i), '0);
			chk(q, d(i));
		end
		chk(index_gpr_zero, d(0));
		chk(stack_pointer, d(15));
		apb(1, 12'h054, 32'hFFFFFFFF);
		apb(0, 12'h054, '0);
		chk({err, q}, {1'b1, 32'h00000000});
		apb(0, 12'h100, '0);
		chk(err, 1'b1);
		apb(1, 12'h040, 32'h0FFF00F0);
		apb(0, 12'h040, '0);
		chk(q[27:16], 12'hFFF);
		gpr_wr_en   <= 1'b1;
		gpr_wr_data <= 32'hCAFE0000;
		#1 chk(rd_a_data, 32'hCAFE0000);
		chk(rd_b_data, 32'hCAFE0000);
		@(posedge pclk);
		gpr_wr_en <= 1'b0;
		#1 chk(index_gpr_zero, 32'hCAFE0000);
		apb(1, 12'h03C, 32'h00000200);
		exc_push <= 1'b1;
		@(posedge pclk);
		exc_pop <= 1'b1;
		#1 chk(stack_pointer, 32'h000001F8);
		step_chk(32'h000001F0);
		chk(stack_pointer, 32'h000001F0);
		exc_push <= 1'b0;
		step_chk(32'h000001F8);
		chk(stack_pointer, 32'h000001F8);
		exc_pop <= 1'b0;
		ctl(dsrf_pkg::DSRF_CTL_LOOP_START, 32'h00000100);
		ctl(dsrf_pkg::DSRF_CTL_LOOP_END, 32'h00000104);
		ctl(dsrf_pkg::DSRF_CTL_WRAP, 32'h10041000);
		ctl(dsrf_pkg::DSRF_CTL_STATUS, 32'h000304F0);
		chk({loop_start_pointer, loop_end_pointer[7:0]}, {32'h00000100, 8'h04});
		chk(wraparound_bounds[31:16], 16'h1004);
		chk(wraparound_bounds[15:0], 16'h1000);
		apb(0, 12'h04C, '0);
		chk(q, 32'h10041000);
		chk(status_word[27:16], 12'h003);
		run <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			#1 n++;
		end while (fetch_pc !== 32'h00000106 && n < 40);
		chk(n, 10);
		chk(status_word[27:16], 12'h001);
		run <= 1'b0;
		apb(1, 12'h010, 32'h00001000);
		x_mode <= dsrf_pkg::DSRF_AM_INC;
		@(posedge pclk);
		#1 chk(x_addr, 32'h00001002);
		@(posedge pclk);
		#1 chk(x_addr, 32'h00001004);
		@(posedge pclk);
		#1 chk(x_addr, 32'h00001000);
		x_mode <= dsrf_pkg::DSRF_AM_DEC;
		@(posedge pclk);
		#1 chk(x_addr, 32'h00000FFE);
		x_mode <= dsrf_pkg::DSRF_AM_INDEX;
		rd_a_idx <= 4'h4;
		@(posedge pclk);
		x_mode <= dsrf_pkg::DSRF_AM_NONE;
		#1 chk(x_addr, 32'h00000FFE + d(8));
		chk(rd_a_data, 32'h00000FFE + d(8));
		ld_x_en   <= 1'b1;
		ld_x_data <= 32'h40000000;
		ld_y_en   <= 1'b1;
		ld_y_data <= 32'hC0000000;
		@(posedge pclk);
		ld_x_en <= 1'b0;
		ld_y_en <= 1'b0;
		dchk(3'h2, 40'h0040000000);
		dchk(3'h4, 40'hFFC0000000);
		mul_en <= 1'b1;
		@(posedge pclk);
		mul_en <= 1'b0;
		dchk(3'h6, 40'hFFE0000000);
		alu_wr_en   <= 1'b1;
		alu_wr_data <= 40'h8012345678;
		@(posedge pclk);
		alu_wr_en <= 1'b0;
		dchk(3'h0, 40'h8012345678);
		apb(0, 12'h064, '0);
		chk(q[7:0], 8'h80);
		flags_wr_en   <= 1'b1;
		flags_wr_data <= 32'h00000035;
		@(posedge pclk);
		flags_wr_en <= 1'b0;
		apb(0, 12'h050, '0);
		chk({dsp_flags, q}, {32'h00000035, 32'h00000035});
		y_mode <= dsrf_pkg::DSRF_AM_INC;
		@(posedge pclk);
		y_mode <= dsrf_pkg::DSRF_AM_NONE;
		#1 chk(y_addr, d(6) + 32'h00000002);
		ce       <= 1'b0;
		exc_push <= 1'b1;
		@(posedge pclk);
		#1 chk(stack_pointer, 32'h000001F8);
		ce       <= 1'b1;
		exc_push <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			{dsp_valid, dsp_is_32, dsp_has_arith} <= 3'(k);
			@(posedge pclk);
			#1 chk(dsp_len_err, k == 5);
		end
		results();
	end
endmodule : tb_top

bind dsrf_top dsrf_top_asserts dsrf_top_asserts_inst (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
	.gpr_wr_en, .gpr_wr_idx, .gpr_wr_data, .rd_a_idx, .rd_a_data, .index_gpr_zero, .stack_pointer,
	.exc_push, .exc_pop, .ctl_wr_en, .status_word, .loop_start_pointer, .loop_end_pointer, .fetch_valid,
	.fetch_pc, .loop_redirect, .loop_target, .dsp_valid, .dsp_is_32, .dsp_has_arith, .dsp_len_err);
